// ==== verilog/rdsm_pkg.sv ====
package rdsm_pkg;
   // ****************************************
   // lengths and modes
   // ****************************************
   localparam int LEN_SHORT = 512;
   localparam int LEN_LONG  = 1024;

   typedef enum logic [1:0]
   {
      MODE_RECIRC_QUIET = 2'b00,
      MODE_RECIRC_SHOW  = 2'b01,
      MODE_WRITE        = 2'b10,
      MODE_READ         = 2'b11
   } rdsm_mode_t;

   typedef struct packed
   {
      logic writeCtl;
      logic readCtl;
      logic dataIn;
   } rdsm_ctl_t;

   localparam logic DOUT_RESET = 1'b0;
endpackage

// ==== verilog/rdsm_buf2.sv ====
`timescale 1ns/1ps
`default_nettype none
module rdsm_buf2 #(
   parameter int WIDTH = 1
)(
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic [WIDTH-1:0]      outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   import rdsm_pkg::*;

   // ****************************************
   // two-entry skid buffer
   // ****************************************
   logic [WIDTH-1:0] mem [0:1];
   logic             wrPtr;
   logic             rdPtr;
   logic [1:0]       count;
   logic [1:0]       next_count;
   logic             push;
   logic             pop;

   if (WIDTH < 1)
   begin
      $error("rdsm_buf2: WIDTH must be at least 1");
   end

   assign push       = inValid && inReady;
   assign pop        = outValid && outReady;
   assign next_count = count + {1'b0, push} - {1'b0, pop};
   assign outData    = mem[rdPtr];

   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         wrPtr    <= 1'b0;
         rdPtr    <= 1'b0;
         count    <= 2'h0;
         inReady  <= 1'b1;
         outValid <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wrPtr <= ~wrPtr;
         end
         if (pop)
         begin
            rdPtr <= ~rdPtr;
         end
         count <= next_count;
         // flags registered from the next count: ready pin comes from a flop
         inReady  <= (next_count != 2'h2);
         outValid <= (next_count != 2'h0);
      end
   end
endmodule
`default_nettype wire

// ==== verilog/rdsm_shift_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) write low read low: recirculate, output low
// (R2) write low read high: recirculate, output data
// (R3) write high read low: load input, output low
// (R4) both high: read mode, output data
// (R5) one serial loop, 512 or 1024 bits
// (R6) host keeps shifting; dynamic storage decays; the loop flops here hold their bits between steps
// (R7) one accepted step advances one position
module rdsm_shift_mem #(
   parameter int LENGTH = rdsm_pkg::LEN_SHORT
)(
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire rdsm_pkg::rdsm_ctl_t stepCtl,
   input  wire logic                stepValid,
   output logic                     stepReady,
   output logic                     dataOut,
   output logic                     dataOutValid,
   input  wire logic                dataOutReady
);
   import rdsm_pkg::*;

   // ****************************************
   // parameter check
   // ****************************************
   // only the two loop lengths exist; anything else is refused
   if (LENGTH != LEN_SHORT && LENGTH != LEN_LONG)
   begin
      $error("rdsm_shift_mem: LENGTH must be 512 or 1024");
   end

   // ****************************************
   // output stage states
   // ****************************************
   typedef enum logic
   {
      OUT_EMPTY = 1'b0,
      OUT_FULL  = 1'b1
   } rdsm_out_state_t;

   // ****************************************
   // signals
   // ****************************************
   rdsm_ctl_t       bufCtl;
   logic            bufValid;
   logic            bufReady;
   logic            outBufReady;
   rdsm_mode_t      mode;
   logic            step;
   logic            tapBit;
   logic            next_bit;
   logic            next_out;
   rdsm_out_state_t outState;
   rdsm_out_state_t next_outState;

   // ****************************************
   // input buffer
   // ****************************************
   // the buffer absorbs a stalled receiver so no step is lost
   rdsm_buf2 #(
      .WIDTH ($bits(rdsm_ctl_t))
   ) u_inBuf (
      .clock    (clock),
      .rst      (rst),
      .inData   (stepCtl),
      .inValid  (stepValid),
      .inReady  (stepReady),
      .outData  (bufCtl),
      .outValid (bufValid),
      .outReady (bufReady)
   );

   // ****************************************
   // step handshake
   // ****************************************
   assign mode = rdsm_mode_t'({bufCtl.writeCtl, bufCtl.readCtl});
   // a step only happens when the output side can take the bit
   assign step     = bufValid && outBufReady; // R7
   assign bufReady = outBufReady;
   // output free now, or its bit leaves at this edge
   assign outBufReady = !dataOutValid || dataOutReady;

   // ****************************************
   // mode decode
   // ****************************************
   // write with read low loads the input into the loop, read picks what is shown
   always_comb
   begin
      next_bit = tapBit;
      next_out = 1'b0;
      case (mode)
         MODE_RECIRC_QUIET:
         begin
            next_bit = tapBit; // R1
            next_out = 1'b0; // R1
         end

         MODE_RECIRC_SHOW:
         begin
            next_bit = tapBit; // R2
            next_out = tapBit; // R2
         end

         MODE_WRITE:
         begin
            next_bit = bufCtl.dataIn; // R3
            next_out = 1'b0; // R3
         end

         MODE_READ:
         begin
            next_bit = tapBit; // R4
            next_out = tapBit; // R4
         end

         default:
         begin
            next_bit = tapBit;
            next_out = 1'b0;
         end
      endcase
   end

   // ****************************************
   // serial loop
   // ****************************************
   // no reset on the loop: contents are undefined until written,
   // so a host writes one full lap before it reads
   logic [LENGTH-1:0] loop;

   assign tapBit = loop[LENGTH-1];

   // entry cell takes the recirculated or the written bit
   always_ff @(posedge clock)
   begin
      if (step)
      begin
         loop[0] <= next_bit; // R5 R7
      end
   end

   // every further cell copies its neighbour on a step
   for (genvar p = 1; p < LENGTH; p++)
   begin : g_cell
      always_ff @(posedge clock)
      begin
         if (step)
         begin
            loop[p] <= loop[p-1]; // R5 R7
         end
      end
   end

   // ****************************************
   // output state
   // ****************************************
   // full until the receiver takes the bit and no new step refills it
   always_comb
   begin
      next_outState = outState;
      case (outState)
         OUT_EMPTY:
         begin
            if (step)
            begin
               next_outState = OUT_FULL;
            end
         end
         OUT_FULL:
         begin
            if (!step && dataOutReady)
            begin
               next_outState = OUT_EMPTY;
            end
         end
         default:
         begin
            next_outState = OUT_EMPTY;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         outState <= OUT_EMPTY;
      end
      else
      begin
         outState <= next_outState;
      end
   end

   // ****************************************
   // output registers
   // ****************************************
   // loaded only on a step, so a stalled bit stands
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         dataOut <= DOUT_RESET;
      end
      else if (step)
      begin
         dataOut <= next_out; // R1 R2 R3 R4
      end
   end

   // own flop so the pin comes straight from a register
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         dataOutValid <= 1'b0;
      end
      else
      begin
         dataOutValid <= (next_outState == OUT_FULL); // R7
      end
   end
endmodule
`default_nettype wire

// ==== dv/rdsm_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module rdsm_chk #(
   parameter int LENGTH = 512
)(
   input wire logic                clock,
   input wire logic                rst,
   input wire rdsm_pkg::rdsm_ctl_t stepCtl,
   input wire logic                stepValid,
   input wire logic                stepReady,
   input wire logic                dataOut,
   input wire logic                dataOutValid,
   input wire logic                dataOutReady
);
   import rdsm_pkg::*;
   // steps taken but not yet handed out: the two buffer entries and the output register
   logic [2:0] held;
   wire        take = stepValid && stepReady;
   always_ff @(posedge clock or posedge rst)
      if (rst)
         held <= 3'h0;
      else
         held <= held + 3'(take) - 3'(dataOutValid && dataOutReady);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_stall_hold: assert property (dataOutValid && !dataOutReady |=>
      dataOutValid && $stable(dataOut)) else $error("output moved under stall");
   chk_pair_bound: assert property (held <= 3'h3)
      else $error("too many steps in flight");
   chk_no_phantom: assert property (held == 3'h0 |-> !dataOutValid)
      else $error("output without a step");
   chk_empty_takes: assert property (held == 3'h0 |-> stepReady)
      else $error("empty block refused a step");
   chk_answer_two: assert property (take && held == 3'h0 |-> ##2 dataOutValid)
      else $error("step answer late");
   chk_quiet_zero: assert property (take && held == 3'h0 && !stepCtl.readCtl
      |-> ##2 !dataOut) else $error("output not low");
   cover property (!stepReady);
   cover property (dataOutValid && !dataOutReady);
   cover property (take && stepCtl.writeCtl);
endmodule
bind rdsm_shift_mem rdsm_chk #(.LENGTH(LENGTH)) chk_u (.clock(clock), .rst(rst),
   .stepCtl(stepCtl), .stepValid(stepValid), .stepReady(stepReady), .dataOut(dataOut),
   .dataOutValid(dataOutValid), .dataOutReady(dataOutReady));
`default_nettype wire

// ==== dv/rdsm_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module rdsm_host (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic stall,
   input  wire logic dataOut,
   input  wire logic dataOutValid,
   output logic      dataOutReady
);
   logic got[$];
   // a stalling host takes nothing, so the buffer must fill
   assign dataOutReady = !stall;
   always @(posedge clock)
      if (!rst && dataOutValid && dataOutReady)
         got.push_back(dataOut);
endmodule
`default_nettype wire

// ==== dv/rdsm_shift_mem_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module rdsm_shift_mem_tb;
   import rdsm_pkg::*;
   logic      clock = 1'b0;
   logic      rst = 1'b1;
   logic      stall = 1'b0;
   logic      slow = 1'b0;
   rdsm_ctl_t stepCtl = '0;
   logic      stepValid = 1'b0;
   logic      stepReady, dataOut, dataOutValid, dataOutReady;
   int        error_cnt = 0;
   int        checks_done = 0;
   int        cyc = 0;
   rdsm_shift_mem #(.LENGTH(512)) dut_u (.clock(clock), .rst(rst), .stepCtl(stepCtl),
      .stepValid(stepValid), .stepReady(stepReady), .dataOut(dataOut),
      .dataOutValid(dataOutValid), .dataOutReady(dataOutReady));
   rdsm_host host_u (.clock(clock), .rst(rst), .stall(stall), .dataOut(dataOut),
      .dataOutValid(dataOutValid), .dataOutReady(dataOutReady));
   initial
   begin
      forever #50 clock = ~clock;
   end
   // stall pattern runs free so a refused step is always released
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      stall <= slow && cyc[2];
      if (cyc == 20000)
      begin
         error_cnt++;
         results();
      end
   end
   task automatic compare(input string what, input logic exp, input logic seen);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %b seen %b", what, exp, seen);
      end
   endtask
   function automatic logic pat(input int i);
      return i[0] ^ i[4] ^ i[7];
   endfunction
   // one full lap; laps with write low offer inverted input that must be ignored
   task automatic run_pass(input rdsm_mode_t m, input logic s);
      slow <= s;
      for (int i = 0; i < 512; i++)
      begin
         stepCtl <= {m, m[1] ? pat(i) : ~pat(i)};
         stepValid <= 1'b1;
         do @(posedge clock); while (stepReady !== 1'b1);
      end
      stepValid <= 1'b0;
      slow <= 1'b0;
      for (int t = 0; t < 30 && host_u.got.size() < 512; t++) @(posedge clock);
      compare("count", 1'b1, host_u.got.size() == 512);
      for (int i = 0; i < 512; i++)
         compare("dataOut", m[0] ? pat(i) : 1'b0, host_u.got[i]);
      host_u.got.delete();
   endtask
   task automatic results();
      if (error_cnt == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      run_pass(MODE_WRITE, 1'b0);
      run_pass(MODE_READ, 1'b1);
      run_pass(MODE_RECIRC_SHOW, 1'b0);
      run_pass(MODE_RECIRC_QUIET, 1'b1);
      run_pass(MODE_RECIRC_SHOW, 1'b1);
      results();
   end
endmodule
`default_nettype wire
